//--- lsu_pkg.sv
package lsu_pkg;
   localparam int ADDR_W = 32;
   localparam int DATA_W = 64;
   localparam int TAG_W = 6;
   localparam int REFILL_CYCLES = 8;
   localparam int CACHE_BLOCK_LOG2 = 5;
   localparam int PAGE_LOG2 = 12;
   localparam logic [7:0] LANES_ALL = 8'hFF;
   localparam logic [7:0] LANES_HI = 8'hF0;
   localparam logic [7:0] LANES_LO = 8'h0F;

   typedef enum logic [2:0] {
      OP_LOAD,
      OP_STORE,
      OP_LOAD_MULTI,
      OP_STORE_MULTI,
      OP_STRING,
      OP_SYNC
   } op_t;

   typedef enum logic [1:0] {
      KIND_INT,
      KIND_FP
   } kind_t;
endpackage : lsu_pkg

//--- gather_buffer.sv
`timescale 1ns/10ps
// Holds one pending word store and merges a second eligible one into a doubleword.
module gather_buffer (
   input wire logic clk,
   input wire logic srst,
   input wire logic in_valid,
   input wire logic in_eligible,
   input wire logic [lsu_pkg::ADDR_W-1:0] in_addr,
   input wire logic [31:0] in_data,
   input wire logic [7:0] in_lanes,
   input wire logic barrier,
   input wire logic gather_en,
   input wire logic bus_ready,
   output logic in_ready,
   output logic bus_valid,
   output logic [lsu_pkg::ADDR_W-1:0] bus_addr,
   output logic [lsu_pkg::DATA_W-1:0] bus_data,
   output logic [7:0] bus_lanes,
   output logic bus_merged
);
   logic held_reg;
   logic held_elig_reg;
   logic [lsu_pkg::ADDR_W-1:0] held_addr_reg;
   logic [31:0] held_data_reg;
   logic [7:0] held_lanes_reg;
   logic out_free;
   logic same_dw;
   logic can_merge;
   logic flush_held;

   assign out_free = !bus_valid || bus_ready;
   // Same naturally aligned doubleword, other half; order does not matter
   assign same_dw = held_addr_reg[lsu_pkg::ADDR_W-1:3] == in_addr[lsu_pkg::ADDR_W-1:3]
                    && held_addr_reg[2] != in_addr[2];
   assign can_merge = held_reg && held_elig_reg && in_eligible && gather_en && same_dw && !barrier;
   // A held store leaves when it cannot merge with the newcomer, or a barrier arrives
   assign flush_held = held_reg && (barrier || (in_valid && !can_merge));
   // An empty holder can park a store even while the bus is still busy
   assign in_ready = out_free || !held_reg;

   always_ff @(posedge clk) begin
      if (srst) begin
         held_reg <= 1'b0;
         held_elig_reg <= 1'b0;
         held_addr_reg <= '0;
         held_data_reg <= '0;
         held_lanes_reg <= 8'h00;
         bus_valid <= 1'b0;
         bus_addr <= '0;
         bus_data <= '0;
         bus_lanes <= 8'h00;
         bus_merged <= 1'b0;
      end else if (out_free || !held_reg) begin
         if (out_free) begin
            bus_valid <= 1'b0;
            bus_merged <= 1'b0;
         end
         if (in_valid && can_merge) begin
            // Merged doubleword goes out as one single-beat write
            bus_valid <= 1'b1;
            bus_merged <= 1'b1;
            bus_addr <= {in_addr[lsu_pkg::ADDR_W-1:3], 3'h0};
            bus_data <= in_addr[2] ? {held_data_reg, in_data} : {in_data, held_data_reg};
            bus_lanes <= lsu_pkg::LANES_ALL;
            held_reg <= 1'b0;
         end else begin
            if (flush_held) begin
               bus_valid <= 1'b1;
               bus_addr <= held_addr_reg;
               bus_data <= {held_data_reg, held_data_reg};
               bus_lanes <= held_lanes_reg;
               held_reg <= 1'b0;
            end
            if (in_valid) begin
               // Stores wait in the holder so a later one can join them while pending
               held_reg <= 1'b1;
               held_elig_reg <= in_eligible;
               held_addr_reg <= in_addr;
               held_data_reg <= in_data;
               held_lanes_reg <= in_lanes;
            end
         end
      end
   end

   a_merge_lanes: assert property (@(posedge clk) disable iff (srst)
      bus_valid && bus_merged |-> bus_lanes == 8'hFF && bus_addr[2:0] == 3'h0)
      else $error("merged write lacks full lanes");
   a_no_merge_off: assert property (@(posedge clk) disable iff (srst)
      !$past(gather_en) |-> !(bus_valid && bus_merged && $rose(bus_valid)))
      else $error("merge while gathering disabled");
   a_barrier_flush: assert property (@(posedge clk) disable iff (srst)
      barrier && out_free && !in_valid |=> !held_reg)
      else $error("barrier left a store held");
   c_merge: cover property (@(posedge clk) disable iff (srst) bus_valid && bus_merged);
endmodule : gather_buffer

//--- load_store_unit.sv
`timescale 1ns/10ps
module load_store_unit #(
   parameter int REFILL_CYCLES = lsu_pkg::REFILL_CYCLES
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic in_valid,
   input wire lsu_pkg::op_t in_op,
   input wire lsu_pkg::kind_t in_kind,
   input wire logic [3:0] in_size,
   input wire logic [lsu_pkg::ADDR_W-1:0] in_base,
   input wire logic [lsu_pkg::ADDR_W-1:0] in_offset,
   input wire logic [31:0] in_data,
   input wire logic [lsu_pkg::TAG_W-1:0] in_tag,
   input wire logic in_byte_rev,
   input wire logic in_cond,
   input wire logic in_ext_ctl,
   input wire logic little_endian,
   input wire logic store_gather_enable,
   input wire logic table_search,
   input wire logic attr_write_through,
   input wire logic attr_inhibited,
   input wire logic attr_guarded,
   input wire logic attr_protect_cross,
   input wire logic [lsu_pkg::ADDR_W-1:0] pa_offset,
   input wire logic cache_hit,
   input wire logic [31:0] cache_rdata,
   input wire logic refill_done,
   input wire logic bus_ready,
   output logic in_ready,
   output logic done_valid,
   output logic [lsu_pkg::TAG_W-1:0] done_tag,
   output logic [31:0] done_data,
   output logic align_exc,
   output logic split_pending,
   output logic refill_req,
   output logic [lsu_pkg::ADDR_W-1:0] refill_addr,
   output logic bus_valid,
   output logic [lsu_pkg::ADDR_W-1:0] bus_addr,
   output logic [lsu_pkg::DATA_W-1:0] bus_data,
   output logic [7:0] bus_lanes,
   output logic bus_merged
);
   typedef enum {ST_RUN, ST_SPLIT, ST_MISS} state_t;

   function automatic logic [7:0] lane_mask(input logic [2:0] a, input logic [3:0] sz);
      lane_mask = 8'h00;
      for (int i = 0; i < 8; i++) begin
         if (i >= a && i < a + sz) lane_mask[7-i] = 1'b1;
      end
   endfunction : lane_mask

   state_t state_reg, state_next;

   // Stage 1: address calculation and translation
   logic [lsu_pkg::ADDR_W-1:0] ea;
   logic [lsu_pkg::ADDR_W-1:0] last_byte;
   logic aligned, word_aligned, cross_dw, cross_blk, crossing, multi_op;
   logic trap, needs_split, stall;
   logic s2_valid_reg, s2_load_reg, s2_store_reg, s2_elig_reg, s2_exc_reg, s2_split_reg;
   logic [lsu_pkg::ADDR_W-1:0] s2_addr_reg;
   logic [31:0] s2_data_reg;
   logic [3:0] s2_size_reg;
   logic [lsu_pkg::TAG_W-1:0] s2_tag_reg;
   logic [7:0] s2_lanes_reg;
   logic s2_barrier_reg;
   logic eligible;
   logic gb_ready;
   logic [$clog2(REFILL_CYCLES+1)-1:0] refill_cnt_reg;

   assign ea = in_base + in_offset;
   assign last_byte = ea + {28'h0, in_size} - 32'h1;
   assign multi_op = in_op == lsu_pkg::OP_LOAD_MULTI || in_op == lsu_pkg::OP_STORE_MULTI;
   assign aligned = (ea & ({28'h0, in_size} - 32'h1)) == 32'h0;
   assign word_aligned = ea[1:0] == 2'h0;
   assign cross_dw = ea[lsu_pkg::ADDR_W-1:3] != last_byte[lsu_pkg::ADDR_W-1:3];
   assign cross_blk = ea[lsu_pkg::ADDR_W-1:lsu_pkg::CACHE_BLOCK_LOG2]
                      != last_byte[lsu_pkg::ADDR_W-1:lsu_pkg::CACHE_BLOCK_LOG2];
   assign crossing = cross_dw || cross_blk || attr_protect_cross;
   // Endian mode plays no part below except for multi/string ops
   assign trap = (little_endian && (multi_op || in_op == lsu_pkg::OP_STRING))
                 || (multi_op && !word_aligned)
                 || (in_kind == lsu_pkg::KIND_FP && in_size == 4'h4 && !word_aligned)
                 || (in_kind == lsu_pkg::KIND_FP && in_size == 4'h8 && !word_aligned && crossing);
   // Everything else that crosses a boundary takes extra address calculations
   assign needs_split = !trap && ((multi_op || in_op == lsu_pkg::OP_STRING)
                        || (!aligned && crossing));
   // Stores eligible for gathering; identical in either endian mode
   assign eligible = in_op == lsu_pkg::OP_STORE && in_kind == lsu_pkg::KIND_INT
                     && in_size == 4'h4 && word_aligned && !attr_guarded
                     && (attr_write_through || attr_inhibited)
                     && !in_byte_rev && !in_cond && !in_ext_ctl && !table_search;

   // Miss blocks further cache accesses; split holds for one more calc cycle
   logic miss_now, gb_needed;
   logic [lsu_pkg::TAG_W-1:0] miss_tag_reg;
   // The op behind a missing load is taken, then parked until the refill ends
   assign miss_now = s2_valid_reg && s2_load_reg && !s2_exc_reg && !cache_hit;
   assign gb_needed = s2_valid_reg && ((s2_store_reg && !s2_exc_reg) || s2_barrier_reg);
   // A store or barrier the holder cannot take waits here rather than being lost
   assign stall = gb_needed && !gb_ready;
   logic busy;
   assign busy = state_reg != ST_RUN || stall;

   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         ST_RUN: begin
            if (miss_now) state_next = ST_MISS;
            else if (in_valid && needs_split && !busy) state_next = ST_SPLIT;
         end
         ST_SPLIT: state_next = ST_RUN;
         ST_MISS: if (refill_done) state_next = ST_RUN;
      endcase
   end

   always_ff @(posedge clk) begin
      if (srst) state_reg <= ST_RUN;
      else state_reg <= state_next;
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         s2_valid_reg <= 1'b0;
         s2_load_reg <= 1'b0;
         s2_store_reg <= 1'b0;
         s2_elig_reg <= 1'b0;
         s2_exc_reg <= 1'b0;
         s2_split_reg <= 1'b0;
         s2_barrier_reg <= 1'b0;
         s2_addr_reg <= '0;
         s2_data_reg <= 32'h0;
         s2_size_reg <= 4'h0;
         s2_tag_reg <= '0;
         s2_lanes_reg <= 8'h00;
      end else if (!busy) begin
         // One new operation accepted per cycle
         s2_valid_reg <= in_valid;
         s2_load_reg <= in_op == lsu_pkg::OP_LOAD || in_op == lsu_pkg::OP_LOAD_MULTI
                        || in_op == lsu_pkg::OP_STRING;
         s2_store_reg <= in_op == lsu_pkg::OP_STORE || in_op == lsu_pkg::OP_STORE_MULTI;
         s2_elig_reg <= eligible;
         s2_exc_reg <= trap;
         s2_split_reg <= needs_split;
         s2_barrier_reg <= in_valid && in_op == lsu_pkg::OP_SYNC;
         s2_addr_reg <= ea + pa_offset;
         s2_data_reg <= in_data;
         s2_size_reg <= in_size;
         s2_tag_reg <= in_tag;
         s2_lanes_reg <= lane_mask(ea[2:0], in_size);
      end
   end

   // Stage 2: cache access and completion
   logic fire;
   // Split ops spend their extra cycle parked, so they fire only back in run
   assign fire = s2_valid_reg && state_reg == ST_RUN && !miss_now && !stall;
   // Ready is decided in this cycle; a registered copy would admit ops that then get dropped
   assign in_ready = !busy && !srst;

   always_ff @(posedge clk) begin
      if (srst) begin
         done_valid <= 1'b0;
         done_tag <= '0;
         done_data <= 32'h0;
         align_exc <= 1'b0;
         split_pending <= 1'b0;
         miss_tag_reg <= '0;
         refill_req <= 1'b0;
         refill_addr <= '0;
         refill_cnt_reg <= '0;
      end else begin
         if (miss_now && state_reg == ST_RUN) miss_tag_reg <= s2_tag_reg;
         done_valid <= fire || (state_reg == ST_MISS && refill_done);
         done_tag <= (state_reg == ST_MISS) ? miss_tag_reg : s2_tag_reg;
         done_data <= cache_rdata;
         align_exc <= fire && s2_exc_reg;
         split_pending <= state_next == ST_SPLIT;
         refill_req <= state_next == ST_MISS && state_reg == ST_RUN;
         if (state_reg == ST_RUN) refill_addr <= s2_addr_reg;
         if (state_reg == ST_MISS) refill_cnt_reg <= refill_cnt_reg + 1'b1;
         else refill_cnt_reg <= '0;
      end
   end

   gather_buffer u_gather (
      .clk(clk),
      .srst(srst),
      .in_valid(fire && s2_store_reg && !s2_exc_reg),
      .in_eligible(s2_elig_reg),
      .in_addr(s2_addr_reg),
      .in_data(s2_data_reg),
      .in_lanes(s2_lanes_reg),
      .barrier(s2_barrier_reg),
      .gather_en(store_gather_enable),
      .bus_ready(bus_ready),
      .in_ready(gb_ready),
      .bus_valid(bus_valid),
      .bus_addr(bus_addr),
      .bus_data(bus_data),
      .bus_lanes(bus_lanes),
      .bus_merged(bus_merged)
   );

   a_two_cycle: assert property (@(posedge clk) disable iff (srst)
      in_valid && !busy && state_reg == ST_RUN && in_op == lsu_pkg::OP_STORE && !trap && !needs_split
      |=> ##1 done_valid)
      else $error("store did not complete in two cycles");
   a_miss_block: assert property (@(posedge clk) disable iff (srst)
      state_reg == ST_MISS && !refill_done |=> !done_valid || state_reg == ST_RUN)
      else $error("cache access during refill");
   a_le_multi_trap: assert property (@(posedge clk) disable iff (srst)
      in_valid && !busy && little_endian && multi_op |=> s2_exc_reg)
      else $error("little-endian multiple op not trapped");
   a_fp_trap: assert property (@(posedge clk) disable iff (srst)
      in_valid && !busy && in_kind == lsu_pkg::KIND_FP && in_size == 4'h4 && ea[1:0] != 2'h0
      |=> s2_exc_reg)
      else $error("misaligned fp word not trapped");
   a_split_once: assert property (@(posedge clk) disable iff (srst)
      state_reg == ST_SPLIT |=> state_reg != ST_SPLIT)
      else $error("split held too long");
   a_no_gather_fp: assert property (@(posedge clk) disable iff (srst)
      in_valid && !busy && in_kind == lsu_pkg::KIND_FP |=> !s2_elig_reg)
      else $error("fp store marked for gathering");
   c_miss: cover property (@(posedge clk) disable iff (srst) state_reg == ST_MISS ##1 refill_done);
   c_split: cover property (@(posedge clk) disable iff (srst) state_reg == ST_SPLIT);
   c_trap: cover property (@(posedge clk) disable iff (srst) align_exc);
endmodule : load_store_unit

//--- cache_bus_model.sv
`timescale 1ns/10ps
// Cache answers the op in stage 2 with what the bench armed at its take edge
module cache_bus_model (
   input wire logic clk,
   input wire logic srst,
   input wire logic miss_arm,
   input wire logic [31:0] rd_word,
   input wire logic [3:0] bus_wait,
   input wire logic refill_req,
   input wire logic bus_valid,
   output logic cache_hit,
   output logic [31:0] cache_rdata,
   output logic refill_done,
   output logic bus_ready
);
   logic [3:0] rcnt_reg;
   logic [3:0] bcnt_reg;
   always_ff @(posedge clk) begin
      cache_hit <= srst | ~miss_arm;
      cache_rdata <= rd_word;
      refill_done <= 1'b0;
      bus_ready <= 1'b0;
      if (srst) begin
         rcnt_reg <= 4'h0;
         bcnt_reg <= 4'h0;
      end else begin
         if (refill_req) begin
            rcnt_reg <= 4'h6;
         end else if (rcnt_reg != 4'h0) begin
            rcnt_reg <= rcnt_reg - 4'h1;
            refill_done <= (rcnt_reg == 4'h1);
         end
         // Stalls the write for bus_wait+1 cycles so held stores see back-pressure
         if (bus_valid && !bus_ready) begin
            bcnt_reg <= (bcnt_reg == bus_wait) ? 4'h0 : bcnt_reg + 4'h1;
            bus_ready <= (bcnt_reg == bus_wait);
         end
      end
   end
endmodule : cache_bus_model

//--- testbench.sv
`timescale 1ns/10ps
module testbench;
   typedef struct {logic [5:0] tag; logic [31:0] data; logic exc; bit chk; int when;} done_note_t;
   typedef struct {logic [31:0] addr; logic [63:0] data; logic [63:0] msk; logic [7:0] lanes; logic mrg;} bus_note_t;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic in_valid = 1'b0;
   lsu_pkg::op_t in_op = lsu_pkg::OP_LOAD;
   lsu_pkg::kind_t in_kind = lsu_pkg::KIND_INT;
   logic [3:0] in_size = 4'h4;
   logic [31:0] in_base = 32'h0;
   logic [31:0] in_offset = 32'h0;
   logic [31:0] in_data = 32'h0;
   logic [5:0] in_tag = 6'h0;
   logic [7:0] fl = 8'h0;
   logic little_endian = 1'b0;
   logic store_gather_enable = 1'b1;
   logic [31:0] pa_offset = 32'h0;
   logic [31:0] rd_word = 32'h0;
   logic [3:0] bus_wait = 4'h0;
   logic in_ready, done_valid, align_exc, refill_req, bus_valid, bus_merged;
   logic cache_hit, refill_done, bus_ready;
   logic [5:0] done_tag;
   logic [31:0] done_data, bus_addr, cache_rdata, seed = 32'h00012D67, wd;
   logic [63:0] bus_data;
   logic [7:0] bus_lanes;
   logic [5:0] tag_n = 6'h01;
   int cyc = 0, rcyc = -100, tk, num_errors = 0, cmp_count = 0;
   done_note_t dq[$];
   bus_note_t bq[$];
   logic [7:0] xf [9] = '{8'h0A, 8'h0C, 8'h12, 8'h22, 8'h42, 8'h82, 8'h02, 8'h02, 8'h04};

   load_store_unit #(.REFILL_CYCLES(8)) DUT (.clk, .srst, .in_valid, .in_op, .in_kind, .in_size, .in_base,
      .in_offset, .in_data, .in_tag, .in_byte_rev(fl[4]), .in_cond(fl[5]), .in_ext_ctl(fl[6]), .little_endian,
      .store_gather_enable, .table_search(fl[7]), .attr_write_through(fl[1]), .attr_inhibited(fl[2]),
      .attr_guarded(fl[3]), .attr_protect_cross(1'b0), .pa_offset, .cache_hit, .cache_rdata, .refill_done,
      .bus_ready, .in_ready, .done_valid, .done_tag, .done_data, .align_exc, .split_pending(), .refill_req,
      .refill_addr(), .bus_valid, .bus_addr, .bus_data, .bus_lanes, .bus_merged);
   cache_bus_model far_side (.clk, .srst, .miss_arm(fl[0]), .rd_word, .bus_wait, .refill_req, .bus_valid,
      .cache_hit, .cache_rdata, .refill_done, .bus_ready);

   always #5 clk = ~clk;
   always @(posedge clk) cyc <= cyc + 1;

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr

   task automatic complete_run();
      $display("Comparisons %0d errors %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : complete_run

   task automatic cmp(input string what, input logic [63:0] e, input logic [63:0] g);
      cmp_count++;
      if (g !== e) begin
         num_errors++;
         $display("Error %s expected %h seen %h", what, e, g);
      end
   endtask : cmp

   task automatic check_done(input done_note_t e);
      cmp("done_tag", 64'(e.tag), 64'(done_tag));
      cmp("align_exc", 64'(e.exc), 64'(align_exc));
      if (e.chk) cmp("done_data", 64'(e.data), 64'(done_data));
      if (e.when == -2) cmp("miss_cycle", 64'(rcyc + 1), 64'(cyc));
      else if (e.when >= 0) cmp("done_cycle", 64'(e.when), 64'(cyc));
   endtask : check_done

   task automatic check_bus(input bus_note_t e);
      cmp("bus_addr", 64'({e.addr[31:3], 3'h0}), 64'({bus_addr[31:3], 3'h0}));
      cmp("bus_lanes", 64'(e.lanes), 64'(bus_lanes));
      cmp("bus_data", e.data & e.msk, bus_data & e.msk);
      cmp("bus_merged", 64'(e.mrg), 64'(bus_merged));
   endtask : check_bus

   always @(negedge clk) begin
      if (refill_done === 1'b1) rcyc = cyc;
      if (done_valid === 1'b1 && done_tag !== 6'h3F) begin
         if (dq.size() == 0) cmp("done_extra", 64'h0, 64'h1);
         else check_done(dq.pop_front());
      end
      if (bus_valid === 1'b1 && bus_ready === 1'b1) begin
         if (bq.size() == 0) cmp("bus_extra", 64'h0, 64'h1);
         else check_bus(bq.pop_front());
      end
   end

   // Holds in_valid after the take so back-to-back calls need no extra edge
   task automatic issue(input lsu_pkg::op_t op, input lsu_pkg::kind_t k, input logic [3:0] sz,
         input logic [31:0] a, input logic [7:0] f, input int lat, input logic exc, input bit chk);
      logic rdy;
      int n;
      seed = lfsr(seed);
      wd = seed;
      in_valid <= 1'b1;
      in_op <= op;
      in_kind <= k;
      in_size <= sz;
      in_base <= seed;
      in_offset <= a - seed;
      in_data <= seed;
      rd_word <= ~seed;
      fl <= f;
      in_tag <= (op == lsu_pkg::OP_SYNC) ? 6'h3F : tag_n;
      rdy = 1'b0;
      for (n = 0; n < 200 && !rdy; n++) begin
         @(negedge clk);
         rdy = (in_ready === 1'b1);
         tk = cyc;
         @(posedge clk);
      end
      if (!rdy) begin
         num_errors++;
         complete_run();
      end
      if (op != lsu_pkg::OP_SYNC) dq.push_back('{tag_n, ~wd, exc, chk, (lat > 0) ? tk + lat : lat});
      tag_n = (tag_n == 6'h3E) ? 6'h01 : tag_n + 6'h01;
   endtask : issue

   task automatic idle(input int c);
      in_valid <= 1'b0;
      repeat (c) @(posedge clk);
   endtask : idle

   // Two word stores to one doubleword; endian mode hides the lane order, so data is unchecked there
   task automatic pair(input logic [31:0] dw, input bit desc, input logic [7:0] f, input lsu_pkg::kind_t k,
         input bit mrg, input bit bar);
      logic [31:0] w [2];
      logic [63:0] m;
      int j;
      m = little_endian ? 64'h0 : ~64'h0;
      for (int i = 0; i < 2; i++) begin
         j = i ^ int'(desc);
         issue(lsu_pkg::OP_STORE, k, 4'h4, dw + 32'(j * 4), f, 2, 1'b0, 1'b0);
         w[j] = wd;
         if (!mrg) bq.push_back('{dw + pa_offset + 32'(j * 4), j ? {32'h0, wd} : {wd, 32'h0},
            j ? 64'h0000_0000_FFFF_FFFF & m : 64'hFFFF_FFFF_0000_0000 & m,
            j ? lsu_pkg::LANES_LO : lsu_pkg::LANES_HI, 1'b0});
         if (bar || i == 1) begin
            if (mrg) bq.push_back('{dw + pa_offset, {w[0], w[1]}, m, lsu_pkg::LANES_ALL, 1'b1});
            issue(lsu_pkg::OP_SYNC, lsu_pkg::KIND_INT, 4'h4, dw, 8'h00, -1, 1'b0, 1'b0);
         end
      end
   endtask : pair

   initial begin
      seed = lfsr(seed);
      pa_offset = {seed[31:12], 12'h000};
      repeat (10) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      for (int i = 0; i < 4; i++) issue(lsu_pkg::OP_LOAD, lsu_pkg::KIND_INT, 4'h4, 32'h2000 + 32'(i * 4),
         8'h00, 2, 1'b0, 1'b1);
      issue(lsu_pkg::OP_LOAD, lsu_pkg::KIND_INT, 4'h2, 32'h2012, 8'h00, 2, 1'b0, 1'b0);
      issue(lsu_pkg::OP_LOAD, lsu_pkg::KIND_INT, 4'h1, 32'h2013, 8'h00, 2, 1'b0, 1'b0);
      issue(lsu_pkg::OP_LOAD, lsu_pkg::KIND_INT, 4'h4, 32'h2001, 8'h00, 2, 1'b0, 1'b0);
      issue(lsu_pkg::OP_LOAD, lsu_pkg::KIND_FP, 4'h8, 32'h2008, 8'h00, 2, 1'b0, 1'b0);
      issue(lsu_pkg::OP_LOAD, lsu_pkg::KIND_INT, 4'h4, 32'h6000, 8'h01, -2, 1'b0, 1'b0);
      issue(lsu_pkg::OP_LOAD, lsu_pkg::KIND_INT, 4'h4, 32'h6040, 8'h00, -1, 1'b0, 1'b1);
      for (int e = 0; e < 2; e++) begin
         idle(12);
         little_endian <= e[0];
         @(posedge clk);
         issue(lsu_pkg::OP_LOAD, lsu_pkg::KIND_INT, 4'h4, 32'h3006, 8'h00, 3, 1'b0, 1'b0);
         issue(lsu_pkg::OP_LOAD, lsu_pkg::KIND_FP, 4'h8, 32'h300C, 8'h00, 3, 1'b0, 1'b0);
         issue(lsu_pkg::OP_STORE_MULTI, lsu_pkg::KIND_INT, 4'h4, 32'h3002, 8'h00, -1, 1'b1, 1'b0);
         issue(lsu_pkg::OP_LOAD, lsu_pkg::KIND_FP, 4'h4, 32'h3001, 8'h00, -1, 1'b1, 1'b0);
         issue(lsu_pkg::OP_LOAD, lsu_pkg::KIND_FP, 4'h8, 32'h3006, 8'h00, -1, 1'b1, 1'b0);
         if (e == 1) begin
            issue(lsu_pkg::OP_LOAD_MULTI, lsu_pkg::KIND_INT, 4'h4, 32'h3000, 8'h00, -1, 1'b1, 1'b0);
            issue(lsu_pkg::OP_STRING, lsu_pkg::KIND_INT, 4'h4, 32'h3000, 8'h00, -1, 1'b1, 1'b0);
         end
         pair(32'h4000 + 32'(e * 16), 1'b0, 8'h02, lsu_pkg::KIND_INT, 1'b1, 1'b0);
         pair(32'h4008 + 32'(e * 16), 1'b1, 8'h04, lsu_pkg::KIND_INT, 1'b1, 1'b0);
      end
      idle(12);
      little_endian <= 1'b0;
      @(posedge clk);
      for (int x = 0; x < 9; x++) begin
         idle(12);
         store_gather_enable <= (x != 6);
         bus_wait <= 4'(x % 3);
         pair(32'h5000 + 32'(x * 16), x[0], xf[x], (x == 7) ? lsu_pkg::KIND_FP : lsu_pkg::KIND_INT,
            1'b0, x == 8);
      end
      idle(1);
      for (int k = 0; k < 300 && (dq.size() + bq.size()) > 0; k++) @(posedge clk);
      if (dq.size() + bq.size() > 0) num_errors++;
      complete_run();
   end
endmodule : testbench
